/* File: clock_startup_pkg.sv */
// package: fuse layout, sequencer states, register map and start-up counts
package clock_startup_pkg;
    localparam int unsigned WDT_OSC_HZ     = 128000;
    localparam int unsigned TOUT_SHORT_MS  = 4;
    localparam int unsigned TOUT_LONG_MS   = 65;
    localparam int unsigned TOUT_SHORT_CYC = TOUT_SHORT_MS * WDT_OSC_HZ / 1000;
    localparam int unsigned TOUT_LONG_CYC  = TOUT_LONG_MS * WDT_OSC_HZ / 1000;
    localparam logic [16:0] CK_EXT         = 17'h00006;
    localparam logic [16:0] CK_258         = 17'h00102;
    localparam logic [16:0] CK_1K          = 17'h00400;
    localparam logic [16:0] CK_16K         = 17'h04000;
    localparam logic [16:0] CK_32K         = 17'h08000;
    localparam logic [16:0] CK_RESET_EXTRA = 17'h0000E;
    localparam logic [2:0]  DIV_LAST       = 3'h7;
    localparam logic [7:0]  ADDR_FUSE      = 8'h00;
    localparam logic [7:0]  ADDR_CTRL      = 8'h04;
    localparam logic [7:0]  ADDR_STATUS    = 8'h08;
    localparam logic [7:0]  FUSE_RESET     = 8'h22;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic       divide_by_eight_fuse;
        logic       spare;
        logic [1:0] startup_time_fuses;
        logic [3:0] clock_select_fuses;
    } fuse_t;

    typedef enum logic [1:0] {TOUT_NONE, TOUT_SHORT, TOUT_LONG} tout_t;

    typedef struct packed {
        tout_t       toutSel;
        logic [16:0] startupCk;
        logic        lpMode;
        logic [1:0]  lpRange;
    } decode_t;

    typedef enum logic [2:0] {
        ST_HOLD  = 3'h0,
        ST_TOUT  = 3'h1,
        ST_START = 3'h3,
        ST_RUN   = 3'h2,
        ST_SLEEP = 3'h6
    } state_t;

    typedef struct packed {
        logic [6:0]  spare;
        logic [16:0] rippleCount;
        logic [1:0]  lpRange;
        logic        lpMode;
        logic        fromReset;
        logic        coreReset;
        state_t      state;
    } status_t;
endpackage

/* File: clock_startup_reset_sequencer.sv */
// start-up reset sequencer with fuse register on an AXI4-Lite slave
`timescale 1ns/1ps
module clock_startup_reset_sequencer #(
    parameter logic [16:0] TOUT_LONG_CYCLES = 17'(clock_startup_pkg::TOUT_LONG_CYC),
    parameter logic [16:0] STARTUP_16K      = clock_startup_pkg::CK_16K,
    parameter logic [16:0] STARTUP_32K      = clock_startup_pkg::CK_32K
) (
    // clock and reset
    input  logic        clk,
    input  logic        rst,
    input  logic        ce,
    // pins from outside the clock domain
    input  logic        wdtOscPin,
    input  logic        sysOscPin,
    input  logic        resetSourcePin,
    input  logic        wakePin,
    // core control
    output logic        coreReset,
    output logic        coreClkEn,
    // axi4-lite write
    input  logic [7:0]  awaddr,
    input  logic        awvalid,
    output logic        awready,
    input  logic [31:0] wdata,
    input  logic [3:0]  wstrb,
    input  logic        wvalid,
    output logic        wready,
    output logic [1:0]  bresp,
    output logic        bvalid,
    input  logic        bready,
    // axi4-lite read
    input  logic [7:0]  araddr,
    input  logic        arvalid,
    output logic        arready,
    output logic [31:0] rdata,
    output logic [1:0]  rresp,
    output logic        rvalid,
    input  logic        rready
);
    logic [3:0]                   syncA;
    logic [3:0]                   syncB;
    logic [3:0]                   syncC;
    logic                         wdtTick;
    logic                         sysTick;
    logic                         resetSrc;
    logic                         wakeLvl;
    clock_startup_pkg::fuse_t     fuse;
    clock_startup_pkg::fuse_t     next_fuse;
    clock_startup_pkg::decode_t   dec;
    clock_startup_pkg::state_t    state;
    clock_startup_pkg::state_t    next_state;
    clock_startup_pkg::status_t   status;
    logic [16:0]                  toutCycles;
    logic [16:0]                  toutCount;
    logic                         toutDone;
    logic [16:0]                  rippleTarget;
    logic [16:0]                  rippleCount;
    logic                         rippleDone;
    logic                         fromReset;
    logic                         next_fromReset;
    logic                         next_coreReset;
    logic                         next_coreClkEn;
    logic [2:0]                   divCount;
    logic [2:0]                   next_divCount;
    logic                         divHit;
    logic                         sleepReq;
    logic                         next_sleepReq;
    logic                         wrFire;
    logic                         rdFire;
    logic [1:0]                   next_bresp;
    logic                         next_bvalid;
    logic [31:0]                  next_rdata;
    logic [1:0]                   next_rresp;
    logic                         next_rvalid;

    // pin synchronisers: bit 0 watchdog, 1 system osc, 2 reset source, 3 wake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA <= 4'h4;
            syncB <= 4'h4;
            syncC <= 4'h4;
        end else if (ce) begin
            syncA <= {wakePin, resetSourcePin, sysOscPin, wdtOscPin};
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    assign wdtTick  = syncB[0] && !syncC[0];
    assign sysTick  = syncB[1] && !syncC[1];
    assign resetSrc = syncB[2];
    assign wakeLvl  = syncB[3];

    fuse_decode #(
        .LONG_CYC (TOUT_LONG_CYCLES),
        .CK16K    (STARTUP_16K),
        .CK32K    (STARTUP_32K)
    ) u_decode (
        .fuse       (fuse),
        .dec        (dec),
        .toutCycles (toutCycles)
    );

    // time-out counter on watchdog ticks
    tick_counter u_tout (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .clear  (state != clock_startup_pkg::ST_TOUT),
        .tick   (wdtTick),
        .target (toutCycles),
        .count  (toutCount),
        .done   (toutDone)
    );

    // reset start adds the fixed extra cycles
    assign rippleTarget = fromReset ?
        17'(dec.startupCk + clock_startup_pkg::CK_RESET_EXTRA) : dec.startupCk;

    // ripple counter on system oscillator ticks
    tick_counter u_ripple (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .clear  (state != clock_startup_pkg::ST_START),
        .tick   (sysTick),
        .target (rippleTarget),
        .count  (rippleCount),
        .done   (rippleDone)
    );

    // sequencer
    always_comb begin
        next_state     = state;
        next_fromReset = fromReset;
        case (state)
            clock_startup_pkg::ST_HOLD: begin
                if (!resetSrc) begin
                    next_state = clock_startup_pkg::ST_TOUT;
                end
            end
            clock_startup_pkg::ST_TOUT: begin
                if (resetSrc) begin
                    next_state = clock_startup_pkg::ST_HOLD;
                end else if (toutDone) begin
                    next_state     = clock_startup_pkg::ST_START;
                    next_fromReset = 1'b1;
                end
            end
            clock_startup_pkg::ST_START: begin
                if (resetSrc) begin
                    next_state = clock_startup_pkg::ST_HOLD;
                end else if (rippleDone) begin
                    next_state = clock_startup_pkg::ST_RUN;
                end
            end
            clock_startup_pkg::ST_RUN: begin
                if (resetSrc) begin
                    next_state = clock_startup_pkg::ST_HOLD;
                end else if (sleepReq) begin
                    next_state = clock_startup_pkg::ST_SLEEP;
                end
            end
            clock_startup_pkg::ST_SLEEP: begin
                if (resetSrc) begin
                    next_state = clock_startup_pkg::ST_HOLD;
                end else if (wakeLvl) begin
                    next_state     = clock_startup_pkg::ST_START;
                    next_fromReset = 1'b0;
                end
            end
            default: begin
                next_state = clock_startup_pkg::ST_HOLD;
            end
        endcase
        next_coreReset = (next_state != clock_startup_pkg::ST_RUN);
        divHit = fuse.divide_by_eight_fuse || (divCount == clock_startup_pkg::DIV_LAST);
        next_divCount = 3'h0;
        if (state == clock_startup_pkg::ST_RUN && sysTick) begin
            next_divCount = 3'(divCount + 3'h1);
        end else if (state == clock_startup_pkg::ST_RUN) begin
            next_divCount = divCount;
        end
        next_coreClkEn = (state == clock_startup_pkg::ST_RUN) && !resetSrc
            && sysTick && divHit;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= clock_startup_pkg::ST_HOLD;
            fromReset <= 1'b1;
            coreReset <= 1'b1;
            coreClkEn <= 1'b0;
            divCount  <= 3'h0;
        end else if (ce) begin
            state     <= next_state;
            fromReset <= next_fromReset;
            coreReset <= next_coreReset;
            coreClkEn <= next_coreClkEn;
            divCount  <= next_divCount;
        end
    end

    // register slave
    assign wrFire  = awvalid && wvalid && !bvalid && ce;
    assign awready = wrFire;
    assign wready  = wrFire;
    assign arready = !rvalid && ce;
    assign rdFire  = arvalid && arready;

    always_comb begin
        status             = '0;
        status.rippleCount = rippleCount;
        status.lpRange     = dec.lpRange;
        status.lpMode      = dec.lpMode;
        status.fromReset   = fromReset;
        status.coreReset   = coreReset;
        status.state       = state;
    end

    always_comb begin
        next_fuse     = fuse;
        next_sleepReq = sleepReq && (state != clock_startup_pkg::ST_RUN);
        next_bresp    = bresp;
        next_bvalid   = bvalid && !bready;
        next_rdata    = rdata;
        next_rresp    = rresp;
        next_rvalid   = rvalid && !rready;
        if (wrFire) begin
            next_bvalid = 1'b1;
            next_bresp  = clock_startup_pkg::RESP_OKAY;
            if (awaddr == clock_startup_pkg::ADDR_FUSE) begin
                if (wstrb[0]) begin
                    next_fuse = clock_startup_pkg::fuse_t'(wdata[7:0]);
                end
            end else if (awaddr == clock_startup_pkg::ADDR_CTRL) begin
                if (wstrb[0] && wdata[0]) begin
                    next_sleepReq = 1'b1;
                end
            end else if (awaddr != clock_startup_pkg::ADDR_STATUS) begin
                next_bresp = clock_startup_pkg::RESP_SLVERR;
            end
        end
        if (rdFire) begin
            next_rvalid = 1'b1;
            next_rresp  = clock_startup_pkg::RESP_OKAY;
            if (araddr == clock_startup_pkg::ADDR_FUSE) begin
                next_rdata = {24'h000000, fuse};
            end else if (araddr == clock_startup_pkg::ADDR_CTRL) begin
                next_rdata = {31'h00000000, sleepReq};
            end else if (araddr == clock_startup_pkg::ADDR_STATUS) begin
                next_rdata = status;
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = clock_startup_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fuse     <= clock_startup_pkg::fuse_t'(clock_startup_pkg::FUSE_RESET);
            sleepReq <= 1'b0;
            bresp    <= 2'h0;
            bvalid   <= 1'b0;
            rdata    <= 32'h00000000;
            rresp    <= 2'h0;
            rvalid   <= 1'b0;
        end else if (ce) begin
            fuse     <= next_fuse;
            sleepReq <= next_sleepReq;
            bresp    <= next_bresp;
            bvalid   <= next_bvalid;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
            rvalid   <= next_rvalid;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_tout_holds_reset: assert property (
        state == clock_startup_pkg::ST_TOUT |-> coreReset)
        else $error("core left reset during time-out");
    a_tout_ends_start: assert property (
        ce && state == clock_startup_pkg::ST_TOUT && !resetSrc && toutDone
        |=> state == clock_startup_pkg::ST_START && toutCount == toutCycles)
        else $error("time-out end did not start ripple count");
    a_tout_none_skip: assert property (
        ce && state == clock_startup_pkg::ST_TOUT && !resetSrc && toutCycles == 17'h00000
        |=> state == clock_startup_pkg::ST_START)
        else $error("zero time-out did not pass at once");
    a_ripple_release: assert property (
        ce && state == clock_startup_pkg::ST_START && !resetSrc && rippleDone
        |=> state == clock_startup_pkg::ST_RUN && !coreReset)
        else $error("ripple terminal count did not release core");
    a_start_order: assert property (
        state == clock_startup_pkg::ST_START && $past(state) != clock_startup_pkg::ST_START
        |-> $past(state) == (fromReset ? clock_startup_pkg::ST_TOUT : clock_startup_pkg::ST_SLEEP))
        else $error("start-up count entered out of order");
    a_wake_skip_tout: assert property (
        ce && state == clock_startup_pkg::ST_SLEEP && wakeLvl && !resetSrc
        |=> state == clock_startup_pkg::ST_START && !fromReset)
        else $error("wake-up did not go straight to start-up count");
    a_lp_range: assert property (
        fuse.clock_select_fuses[3] |-> dec.lpMode && dec.lpRange == fuse.clock_select_fuses[2:1])
        else $error("low-power range decode wrong");
    a_short_startup: assert property (
        fuse.clock_select_fuses[3] && {fuse.clock_select_fuses[0], fuse.startup_time_fuses} == 3'h0
        |-> dec.startupCk == clock_startup_pkg::CK_258 && toutCycles != 17'h00000)
        else $error("258 cycle setting decoded wrongly");
    a_1k_startup: assert property (
        fuse.clock_select_fuses[3] && {fuse.clock_select_fuses[0], fuse.startup_time_fuses} == 3'h2
        |-> dec.startupCk == clock_startup_pkg::CK_1K && toutCycles == 17'h00000)
        else $error("1K cycle setting decoded wrongly");
    a_16k_startup: assert property (
        fuse.clock_select_fuses[3] && {fuse.clock_select_fuses[0], fuse.startup_time_fuses} == 3'h5
        |-> dec.startupCk == STARTUP_16K && toutCycles == 17'h00000)
        else $error("16K cycle setting decoded wrongly");
    a_div8_rate: assert property (
        coreClkEn && !$past(fuse.divide_by_eight_fuse) |-> $past(divCount) == clock_startup_pkg::DIV_LAST)
        else $error("divided clock enable off the eighth tick");
    a_fuse_default: assert property (
        $past(rst) |-> fuse == clock_startup_pkg::fuse_t'(clock_startup_pkg::FUSE_RESET))
        else $error("fuse default wrong after reset");
    a_ripple_restart: assert property (
        state == clock_startup_pkg::ST_START && $past(state) != clock_startup_pkg::ST_START
        |-> rippleCount == 17'h00000 && !coreClkEn)
        else $error("ripple count not restarted");
    c_reset_to_run: cover property (
        state == clock_startup_pkg::ST_START && fromReset ##1 state == clock_startup_pkg::ST_RUN);
    c_wake_to_run: cover property (
        state == clock_startup_pkg::ST_START && !fromReset ##1 state == clock_startup_pkg::ST_RUN);
    c_div_enable: cover property (coreClkEn && !fuse.divide_by_eight_fuse);
endmodule // clock_startup_reset_sequencer

/* File: fuse_decode.sv */
// decode of clock-select and start-up fuses into counts
`timescale 1ns/1ps
module fuse_decode #(
    parameter logic [16:0] LONG_CYC = 17'(clock_startup_pkg::TOUT_LONG_CYC),
    parameter logic [16:0] CK16K    = clock_startup_pkg::CK_16K,
    parameter logic [16:0] CK32K    = clock_startup_pkg::CK_32K
) (
    // fuses, zero means programmed
    input  clock_startup_pkg::fuse_t   fuse,
    // decoded selection
    output clock_startup_pkg::decode_t dec,
    output logic [16:0]                toutCycles
);
    function automatic clock_startup_pkg::tout_t sutDelay(input logic [1:0] code);
        if (code == 2'h0) begin
            return clock_startup_pkg::TOUT_NONE;
        end else if (code == 2'h1) begin
            return clock_startup_pkg::TOUT_SHORT;
        end
        return clock_startup_pkg::TOUT_LONG;
    endfunction

    always_comb begin
        dec.lpMode  = fuse.clock_select_fuses[3];
        dec.lpRange = fuse.clock_select_fuses[2:1];
        dec.toutSel = sutDelay(fuse.startup_time_fuses);
        dec.startupCk = clock_startup_pkg::CK_EXT;
        // fields are used raw, zero is the programmed state
        if (fuse.clock_select_fuses[3] || fuse.clock_select_fuses[3:1] == 3'h3) begin
            case ({fuse.clock_select_fuses[0], fuse.startup_time_fuses})
                3'h0: begin
                    dec.startupCk = clock_startup_pkg::CK_258;
                    dec.toutSel   = clock_startup_pkg::TOUT_SHORT;
                end
                3'h1: begin
                    dec.startupCk = clock_startup_pkg::CK_258;
                    dec.toutSel   = clock_startup_pkg::TOUT_LONG;
                end
                3'h2: begin
                    dec.startupCk = clock_startup_pkg::CK_1K;
                    dec.toutSel   = clock_startup_pkg::TOUT_NONE;
                end
                3'h3: begin
                    dec.startupCk = clock_startup_pkg::CK_1K;
                    dec.toutSel   = clock_startup_pkg::TOUT_SHORT;
                end
                3'h4: begin
                    dec.startupCk = clock_startup_pkg::CK_1K;
                    dec.toutSel   = clock_startup_pkg::TOUT_LONG;
                end
                3'h5: begin
                    dec.startupCk = CK16K;
                    dec.toutSel   = clock_startup_pkg::TOUT_NONE;
                end
                3'h6: begin
                    dec.startupCk = CK16K;
                    dec.toutSel   = clock_startup_pkg::TOUT_SHORT;
                end
                default: begin
                    dec.startupCk = CK16K;
                    dec.toutSel   = clock_startup_pkg::TOUT_LONG;
                end
            endcase
        end else if (fuse.clock_select_fuses[3:1] == 3'h2) begin
            dec.startupCk = fuse.clock_select_fuses[0] ? CK32K : clock_startup_pkg::CK_1K;
        end
        case (dec.toutSel)
            clock_startup_pkg::TOUT_NONE:  toutCycles = 17'h00000;
            clock_startup_pkg::TOUT_SHORT: toutCycles = 17'(clock_startup_pkg::TOUT_SHORT_CYC);
            default:                       toutCycles = LONG_CYC;
        endcase
    end
endmodule // fuse_decode

/* File: test_clock_startup_reset_sequencer.sv */
// self-checking bench for the start-up reset sequencer
`timescale 1ns/1ps
module test_clock_startup_reset_sequencer;
    logic        clk, rst, ce, wdtOscPin, sysOscPin, resetSourcePin, wakePin;
    logic        coreReset, coreClkEn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs, bs, wdtDiv, sysDiv;
    int          n_fail, total_checks;

    clock_startup_reset_sequencer #(.TOUT_LONG_CYCLES(17'h28), .STARTUP_16K(17'h1E),
        .STARTUP_32K(17'h32)) uut (.clk, .rst, .ce, .wdtOscPin, .sysOscPin, .resetSourcePin,
        .wakePin, .coreReset, .coreClkEn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready);

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    // watchdog oscillator period 4 clk, system oscillator period 6 clk
    always @(posedge clk) begin
        wdtDiv <= wdtDiv + 2'h1;
        sysDiv <= (sysDiv == 2'h2) ? 2'h0 : sysDiv + 2'h1;
        if (wdtDiv[0]) wdtOscPin <= ~wdtOscPin;
        if (sysDiv == 2'h2) sysOscPin <= ~sysOscPin;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic near(string what, int exp, int got, int tol);
        check(what, exp, (got >= exp - tol && got <= exp + tol) ? exp : got);
    endtask

    task automatic axiWrite(logic [7:0] a, logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        bready  <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        bs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axiRead(logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask

    // reset start: cycles from source release to core release
    task automatic startUp(logic [7:0] f, int wdt, int osc);
        int n;
        bit gated;
        n = 0;
        gated = 0;
        axiWrite(clock_startup_pkg::ADDR_FUSE, {24'h0, f});
        resetSourcePin <= 1'b1;
        repeat (8) @(posedge clk);
        check("core reset held", 32'h1, {31'h0, coreReset});
        resetSourcePin <= 1'b0;
        do begin
            @(posedge clk);
            n++;
            if (coreClkEn === 1'b1) gated = 1;
        end while (coreReset !== 1'b0 && n < 20000);
        near("startup cycles", wdt * 4 + osc * 6 + 8, n, 14);
        check("clock gated in start", 32'h0, {31'h0, gated});
        $display("done startup fuse %h", f);
    endtask

    task automatic pulses(int exp);
        int n;
        n = 0;
        repeat (480) begin
            @(posedge clk);
            if (coreClkEn === 1'b1) n++;
        end
        near("core clock pulses", exp, n, 2);
    endtask

    task automatic testRegs;
        axiRead(clock_startup_pkg::ADDR_FUSE);
        check("fuse reset", 32'h22, rd);
        axiRead(8'h0C);
        check("unmapped resp", {30'h0, clock_startup_pkg::RESP_SLVERR}, {30'h0, rs});
        check("unmapped data", 32'h0, rd);
        axiWrite(8'h0C, 32'h0);
        check("unmapped write resp", {30'h0, clock_startup_pkg::RESP_SLVERR}, {30'h0, bs});
        axiWrite(clock_startup_pkg::ADDR_STATUS, 32'h0);
        check("status write resp", {30'h0, clock_startup_pkg::RESP_OKAY}, {30'h0, bs});
        $display("done registers");
    endtask

    task automatic testStartup;
        logic [7:0] f [8] = '{8'h22, 8'h80, 8'h90, 8'hA0, 8'h9E, 8'hAE, 8'h99, 8'h85};
        int         w [8] = '{40, 0, 512, 40, 40, 0, 0, 0};
        int         o [8] = '{20, 20, 20, 20, 272, 1038, 44, 64};
        for (int i = 0; i < 8; i++) startUp(f[i], w[i], o[i]);
    endtask

    task automatic testRange;
        for (int i = 0; i < 4; i++) begin
            axiWrite(clock_startup_pkg::ADDR_FUSE, 32'h88 | (i << 1));
            axiRead(clock_startup_pkg::ADDR_STATUS);
            check("low-power range", {i[1:0], 1'b1}, rd[7:5]);
        end
        $display("done range");
    endtask

    task automatic testSleep;
        int n;
        n = 0;
        startUp(8'h9E, 40, 272);
        axiWrite(clock_startup_pkg::ADDR_CTRL, 32'h1);
        repeat (20) axiRead(clock_startup_pkg::ADDR_STATUS);
        check("sleep state", 32'(clock_startup_pkg::ST_SLEEP), {29'h0, rd[2:0]});
        wakePin <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (coreClkEn !== 1'b1 && n < 20000);
        near("wake cycles", 258 * 6 + 11, n, 14);
        wakePin <= 1'b0;
        axiRead(clock_startup_pkg::ADDR_STATUS);
        check("from reset flag", 32'h0, {31'h0, rd[4]});
        $display("done sleep");
    endtask

    task automatic testDivide;
        pulses(80);
        startUp(8'h22, 40, 20);
        pulses(10);
        $display("done divide");
    endtask

    initial begin
        {ce, rst, wstrb} = 6'h3F;
        {wdtOscPin, sysOscPin, resetSourcePin, wakePin, awvalid, wvalid, bready} = 0;
        {arvalid, rready, wdtDiv, sysDiv, awaddr, araddr, wdata} = 0;
        n_fail = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        testRegs();
        testStartup();
        testRange();
        testSleep();
        testDivide();
        tally_and_finish();
    end

    initial begin
        #900000;
        n_fail++;
        tally_and_finish();
    end
endmodule // test_clock_startup_reset_sequencer

/* File: tick_counter.sv */
// counter of synchronised oscillator ticks up to a target
`timescale 1ns/1ps
module tick_counter (
    // clock and reset
    input  logic        clk,
    input  logic        rst,
    input  logic        ce,
    // count control
    input  logic        clear,
    input  logic        tick,
    input  logic [16:0] target,
    // result
    output logic [16:0] count,
    output logic        done
);
    logic [16:0] next_count;

    assign done = (count >= target);

    always_comb begin
        next_count = count;
        if (clear) begin
            next_count = 17'h00000;
        end else if (tick && !done) begin
            next_count = 17'(count + 17'h00001);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 17'h00000;
        end else if (ce) begin
            count <= next_count;
        end
    end
endmodule // tick_counter
